// ### rtl/radio_cfg_pkg.sv
// Register map constants for the radio configuration register bank.
// Assumes an 8-bit register command path with a 5-bit register address.
`default_nettype none
package radio_cfg_pkg;
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_AUTO_ACK = 5'h01;
  localparam logic [4:0] ADDR_RX_PIPE = 5'h02;
  localparam logic [4:0] ADDR_AW_SETUP = 5'h03;
  localparam logic [4:0] ADDR_TEST_LO = 5'h18;
  localparam logic [4:0] ADDR_TEST_HI = 5'h1b;
  localparam int BIT_RX_MASK = 6;
  localparam int BIT_TX_MASK = 5;
  localparam int BIT_RT_MASK = 4;
  localparam int BIT_CRC_EN = 3;
  localparam int BIT_CRC_LEN = 2;
  localparam int BIT_POWER_UP_CTL = 1;
  localparam int BIT_RECEIVE_ROLE_SEL = 0;
  localparam int NUM_PIPES = 6;
  localparam logic [6:0] CONFIG_RST = 7'h08;
  localparam logic [5:0] AUTO_ACK_RST = 6'h3f;
  localparam logic [5:0] RX_PIPE_RST = 6'h03;
  localparam logic [1:0] AW_RST = 2'h3;
  localparam logic [1:0] AW_ILLEGAL = 2'h0;
  localparam logic [1:0] AW_3B = 2'h1;
  localparam logic [1:0] AW_4B = 2'h2;
  localparam logic [1:0] AW_5B = 2'h3;
  localparam logic [2:0] BYTES_3 = 3'h3;
  localparam logic [2:0] BYTES_4 = 3'h4;
  localparam logic [2:0] BYTES_5 = 3'h5;
endpackage : radio_cfg_pkg
`default_nettype wire

// ### rtl/radio_config_register_bank.sv
// Configuration register bank of the radio transceiver plus its IRQ line.
// Assumes the command decoder presents single-cycle read/write strobes
// with a register address and data, synchronous to clk.
// Functional notes
// - Registers are reached only by read/write commands selecting an address.
// - Undefined bits read back as zero.
// - Bit 6 masks receive-ready flag from the active-low IRQ line.
// - Bit 5 masks transmit-sent flag from the IRQ line.
// - Bit 4 masks retry-limit flag from the IRQ line.
// - CRC enable resets to one, forced one while any auto-ack bit set.
// - Bit 2 selects one-byte (0) or two-byte (1) checksum.
// - Bit 1 powers up; bit 0 selects primary receiver; both reset zero.
// - Six auto-ack enables, all resetting to one.
// - Two-bit address width common to all pipes; 00 illegal.
// - Width 01/10/11 means three/four/five bytes, low bytes used.
// - IRQ stays active until its source flag is cleared by writing one or its mask bit is set.
`timescale 1ns/1ps
`default_nettype none
module radio_config_register_bank
  import radio_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic testAccessErr,
  input wire logic rxDataReadyFlag,
  input wire logic txSentFlag,
  input wire logic retryLimitFlag,
  output logic radioIrqLineN,
  output logic crcEnable,
  output logic crcLengthSel,
  output logic powerUpCtl,
  output logic receiveRoleSel,
  output logic [5:0] pipeAutoAckEn,
  output logic [5:0] pipeRxEn,
  output logic [1:0] addrWidthField,
  output logic [2:0] addrWidthBytes,
  output logic addrWidthIllegal
);
  logic [6:0] config_reg;
  logic [5:0] autoAck_reg;
  logic [5:0] rxPipe_reg;
  logic [1:0] aw_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic testErr_reg;

  // Address decode for write strobes
  wire selCfg = regWrite && (regAddr == ADDR_CONFIG);
  wire selAck = regWrite && (regAddr == ADDR_AUTO_ACK);
  wire selRxp = regWrite && (regAddr == ADDR_RX_PIPE);
  wire selAw = regWrite && (regAddr == ADDR_AW_SETUP);
  wire inTest = (regAddr >= ADDR_TEST_LO) && (regAddr <= ADDR_TEST_HI);

  // Reserved write bits are dropped so they can never read back nonzero
  wire [6:0] cfgNext = selCfg ? regWdata[6:0] : config_reg;
  wire [5:0] ackNext = selAck ? regWdata[5:0] : autoAck_reg;

  // Register storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      config_reg <= CONFIG_RST;
      autoAck_reg <= AUTO_ACK_RST;
      rxPipe_reg <= RX_PIPE_RST;
      aw_reg <= AW_RST;
    end else begin
      config_reg <= cfgNext;
      autoAck_reg <= ackNext;
      if (selRxp) begin
        rxPipe_reg <= regWdata[5:0];
      end
      if (selAw) begin
        aw_reg <= regWdata[1:0];
      end
    end
  end

  // Effective CRC enable: forced while any pipe acknowledges
  assign crcEnable = config_reg[BIT_CRC_EN] | (|autoAck_reg);
  assign crcLengthSel = config_reg[BIT_CRC_LEN];
  assign powerUpCtl = config_reg[BIT_POWER_UP_CTL];
  assign receiveRoleSel = config_reg[BIT_RECEIVE_ROLE_SEL];
  assign addrWidthField = aw_reg;
  assign addrWidthIllegal = (aw_reg == AW_ILLEGAL);

  // Per-pipe enable outputs
  genvar p;
  generate
    for (p = 0; p < NUM_PIPES; p++) begin : gPipe
      assign pipeAutoAckEn[p] = autoAck_reg[p];
      assign pipeRxEn[p] = rxPipe_reg[p];
    end
  endgenerate

  // Width in bytes; shorter widths use the low address bytes
  assign addrWidthBytes = (aw_reg == AW_3B) ? BYTES_3 :
                          (aw_reg == AW_4B) ? BYTES_4 :
                          (aw_reg == AW_5B) ? BYTES_5 : 3'h0;

  // Active-low IRQ: flags stay set until cleared by their owner
  wire rxIrq = rxDataReadyFlag & ~config_reg[BIT_RX_MASK];
  wire txIrq = txSentFlag & ~config_reg[BIT_TX_MASK];
  wire rtIrq = retryLimitFlag & ~config_reg[BIT_RT_MASK];
  assign radioIrqLineN = ~(rxIrq | txIrq | rtIrq);

  // Read mux; unmapped addresses and undefined bits return zero
  wire [7:0] cfgRead = {1'b0, config_reg[6:4], crcEnable, config_reg[2:0]};
  always_comb begin
    rdata_next = rdata_reg;
    if (regRead) begin
      unique case (regAddr)
        ADDR_CONFIG: rdata_next = cfgRead;
        ADDR_AUTO_ACK: rdata_next = {2'h0, autoAck_reg};
        ADDR_RX_PIPE: rdata_next = {2'h0, rxPipe_reg};
        ADDR_AW_SETUP: rdata_next = {6'h00, aw_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data registered; test-range writes are flagged, not performed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      testErr_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      testErr_reg <= regWrite && inTest;
    end
  end
  assign regRdata = rdata_reg;
  assign testAccessErr = testErr_reg;

  // Checks
  crc_forced_a: assert property (@(posedge clk) disable iff (!nrst)
    (|autoAck_reg) |-> crcEnable) else $error("crc not forced");
  crc_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> config_reg[BIT_CRC_EN]) else $error("crc reset wrong");
  rd_reserved_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && (regAddr == ADDR_AW_SETUP) |=> regRdata[7:2] == 6'h00)
    else $error("reserved bits nonzero");
  rd_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && (regAddr > ADDR_AW_SETUP) |=> regRdata == 8'h00)
    else $error("unmapped read nonzero");
  rx_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    rxDataReadyFlag && !config_reg[BIT_RX_MASK] |-> !radioIrqLineN)
    else $error("rx irq missing");
  tx_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    txSentFlag && !config_reg[BIT_TX_MASK] |-> !radioIrqLineN)
    else $error("tx irq missing");
  rt_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    retryLimitFlag && !config_reg[BIT_RT_MASK] |-> !radioIrqLineN)
    else $error("rt irq missing");
  irq_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !rxDataReadyFlag && !txSentFlag && !retryLimitFlag |-> radioIrqLineN)
    else $error("irq without source");
  cfg_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg |=> {crcLengthSel, powerUpCtl, receiveRoleSel} == $past(regWdata[2:0]))
    else $error("config write lost");
  ack_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selAck |=> pipeAutoAckEn == $past(regWdata[5:0]))
    else $error("ack write lost");
  rxp_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selRxp |=> pipeRxEn == $past(regWdata[5:0]))
    else $error("pipe write lost");
  aw_bytes_a: assert property (@(posedge clk) disable iff (!nrst)
    aw_reg != AW_ILLEGAL |-> addrWidthBytes == {1'b0, aw_reg} + 3'h2)
    else $error("width decode wrong");
  aw_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selAw |=> addrWidthField == $past(regWdata[1:0]))
    else $error("width write lost");

  // Reset values seen at the first edge after release
  rst_ack_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> autoAck_reg == AUTO_ACK_RST)
    else $error("auto-ack reset wrong");
  rst_rxp_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> rxPipe_reg == RX_PIPE_RST)
    else $error("pipe reset wrong");
  rst_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> config_reg[6:4] == 3'h0)
    else $error("mask reset wrong");
  rst_role_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> config_reg[2:0] == 3'h0)
    else $error("role reset wrong");
  rst_rdata_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> regRdata == 8'h00)
    else $error("read data reset wrong");

  // Storage only moves on a write that selects it
  cfg_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !selCfg |=> $stable(config_reg))
    else $error("config changed unasked");
  ack_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !selAck |=> $stable(autoAck_reg))
    else $error("auto-ack changed unasked");
  rxp_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !selRxp |=> $stable(rxPipe_reg))
    else $error("pipe changed unasked");
  aw_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !selAw |=> $stable(aw_reg))
    else $error("width changed unasked");
  wr_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
    regWrite && (regAddr > ADDR_AW_SETUP) |=> $stable(config_reg) &&
    $stable(autoAck_reg) && $stable(rxPipe_reg) && $stable(aw_reg))
    else $error("unmapped write landed");

  // Test-range writes must leave the map alone; the error pulse lasts one cycle
  test_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    regWrite && inTest |=> $stable(config_reg) && $stable(autoAck_reg))
    else $error("test write landed");
  test_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    regWrite && inTest |=> testAccessErr)
    else $error("test write not flagged");
  test_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    !(regWrite && inTest) |=> !testAccessErr)
    else $error("test flag spurious");

  // Read-back contents, one cycle after the read strobe
  rd_cfg_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && (regAddr == ADDR_CONFIG) |=> regRdata ==
    {1'b0, $past(config_reg[6:4]), $past(crcEnable), $past(config_reg[2:0])})
    else $error("config read wrong");
  rd_ack_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && (regAddr == ADDR_AUTO_ACK) |=> regRdata == {2'h0, $past(autoAck_reg)})
    else $error("auto-ack read wrong");
  rd_rxp_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && (regAddr == ADDR_RX_PIPE) |=> regRdata == {2'h0, $past(rxPipe_reg)})
    else $error("pipe read wrong");
  rd_aw_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && (regAddr == ADDR_AW_SETUP) |=> regRdata[1:0] == $past(aw_reg))
    else $error("width read wrong");
  rd_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !regRead |=> $stable(regRdata))
    else $error("read data moved");
  rd_bit7_a: assert property (@(posedge clk) disable iff (!nrst)
    !regRdata[7])
    else $error("bit 7 read nonzero");
  // A read in the same cycle as a write returns the old contents
  cfg_noread_a: assert property (@(posedge clk) disable iff (!nrst)
    regRead && regWrite && (regAddr == ADDR_CONFIG) |=>
    regRdata[2:0] == $past(config_reg[2:0]))
    else $error("read saw new value");

  // A set mask keeps its source off the line
  rx_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    config_reg[BIT_RX_MASK] && !txIrq && !rtIrq |-> radioIrqLineN)
    else $error("rx irq not masked");
  tx_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    config_reg[BIT_TX_MASK] && !rxIrq && !rtIrq |-> radioIrqLineN)
    else $error("tx irq not masked");
  rt_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    config_reg[BIT_RT_MASK] && !rxIrq && !txIrq |-> radioIrqLineN)
    else $error("rt irq not masked");
  irq_mask_all_a: assert property (@(posedge clk) disable iff (!nrst)
    (&config_reg[6:4]) |-> radioIrqLineN)
    else $error("irq with all masked");
  irq_source_a: assert property (@(posedge clk) disable iff (!nrst)
    !radioIrqLineN |-> rxDataReadyFlag || txSentFlag || retryLimitFlag)
    else $error("irq low without flag");
  mask_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg |=> config_reg[6:4] == $past(regWdata[6:4]))
    else $error("mask write lost");

  // CRC control: stored bit only shows when no pipe acknowledges
  crc_free_a: assert property (@(posedge clk) disable iff (!nrst)
    !(|autoAck_reg) |-> crcEnable == config_reg[BIT_CRC_EN])
    else $error("crc not from register");
  crc_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg && (|autoAck_reg) |=> crcEnable)
    else $error("crc cleared while forced");
  crc_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    selAck && (regWdata[5:0] == 6'h00) |=> crcEnable == config_reg[BIT_CRC_EN])
    else $error("crc still forced");
  crc_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg |=> config_reg[BIT_CRC_EN] == $past(regWdata[BIT_CRC_EN]))
    else $error("crc write lost");
  crc_len_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg |=> crcLengthSel == $past(regWdata[BIT_CRC_LEN]))
    else $error("crc length write lost");
  pwr_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg |=> powerUpCtl == $past(regWdata[BIT_POWER_UP_CTL]))
    else $error("power write lost");
  role_write_a: assert property (@(posedge clk) disable iff (!nrst)
    selCfg |=> receiveRoleSel == $past(regWdata[BIT_RECEIVE_ROLE_SEL]))
    else $error("role write lost");

  // Width decode: the illegal code yields no byte count
  aw_illegal_a: assert property (@(posedge clk) disable iff (!nrst)
    addrWidthIllegal |-> addrWidthBytes == 3'h0)
    else $error("illegal width decoded");
  aw_legal_a: assert property (@(posedge clk) disable iff (!nrst)
    !addrWidthIllegal |-> (addrWidthBytes >= BYTES_3) && (addrWidthBytes <= BYTES_5))
    else $error("width out of range");
endmodule : radio_config_register_bank
`default_nettype wire

// ### dv/flag_owner_model.sv
// Owner of the three status flags that feed the interrupt line.
// Assumes set and clear pulses come from the bench, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module flag_owner_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] setFlags,
  input wire logic [2:0] clrFlags,
  output logic [2:0] flags
);
  // Each flag held until a one is written to it; set wins a tie
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= 3'h0;
    end else begin
      flags <= (flags & ~clrFlags) | setFlags;
    end
  end
endmodule : flag_owner_model
`default_nettype wire

// ### dv/radio_config_register_bank_tb.sv
// Self-checking bench for the radio configuration register bank.
// Assumes single-cycle read/write strobes and registered read data.
`timescale 1ns/1ps
`default_nettype none
module radio_config_register_bank_tb;
  import radio_cfg_pkg::*;
  logic clk = 0, nrst = 0, regWrite = 0, regRead = 0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic testAccessErr, radioIrqLineN, crcEnable, crcLengthSel, powerUpCtl, receiveRoleSel;
  logic addrWidthIllegal;
  logic [5:0] pipeAutoAckEn, pipeRxEn;
  logic [1:0] addrWidthField;
  logic [2:0] addrWidthBytes, flags, setFlags = 3'h0, clrFlags = 3'h0;
  logic [2:0] bytesTab [4] = '{3'h0, BYTES_3, BYTES_4, BYTES_5};
  int badCount = 0, checked = 0, cyc = 0;
  radio_config_register_bank radio_config_register_bank_i (.clk(clk), .nrst(nrst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .testAccessErr(testAccessErr), .rxDataReadyFlag(flags[0]),
    .txSentFlag(flags[1]), .retryLimitFlag(flags[2]), .radioIrqLineN(radioIrqLineN),
    .crcEnable(crcEnable), .crcLengthSel(crcLengthSel), .powerUpCtl(powerUpCtl),
    .receiveRoleSel(receiveRoleSel), .pipeAutoAckEn(pipeAutoAckEn), .pipeRxEn(pipeRxEn),
    .addrWidthField(addrWidthField), .addrWidthBytes(addrWidthBytes),
    .addrWidthIllegal(addrWidthIllegal));
  flag_owner_model flag_owner_model_i (.clk(clk), .nrst(nrst), .setFlags(setFlags),
    .clrFlags(clrFlags), .flags(flags));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Strobe up for one cycle; settled results looked at 1 ns after the taking edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk) regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk) {regRead, regAddr} <= {1'b1, a};
    @(posedge clk) regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rd
  task automatic flagPulse(input logic [2:0] s, input logic [2:0] c);
    @(posedge clk) {setFlags, clrFlags} <= {s, c};
    @(posedge clk) {setFlags, clrFlags} <= 6'h00;
    #1;
  endtask : flagPulse
  task automatic end_sim;
    if (badCount == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // Free-running clock and a hang guard well beyond the sequence length
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      badCount++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chk(radioIrqLineN, 8'h01);
    rd(ADDR_CONFIG, 8'h08);
    rd(ADDR_AUTO_ACK, 8'h3f);
    rd(ADDR_RX_PIPE, 8'h03);
    rd(ADDR_AW_SETUP, 8'h03);
    wr(ADDR_CONFIG, 8'h87); // Reserved bit written high on purpose
    chk({crcLengthSel, powerUpCtl, receiveRoleSel}, 8'h07);
    rd(ADDR_CONFIG, 8'h0f);
    wr(ADDR_AUTO_ACK, 8'h00);
    chk(crcEnable, 8'h00);
    rd(ADDR_CONFIG, 8'h07);
    wr(ADDR_AUTO_ACK, 8'hff);
    chk(pipeAutoAckEn, 8'h3f);
    chk(crcEnable, 8'h01);
    wr(ADDR_RX_PIPE, 8'hfc);
    rd(ADDR_RX_PIPE, 8'h3c);
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_AW_SETUP, 8'hfc | v[7:0]);
      chk(addrWidthBytes, bytesTab[v]);
      chk(addrWidthIllegal, (v == 0) ? 8'h01 : 8'h00);
      rd(ADDR_AW_SETUP, v[7:0]);
    end
    // Test addresses are refused and flagged; nothing mapped may change
    for (int a = 24; a < 28; a++) begin
      wr(a[4:0], 8'h00);
      chk(testAccessErr, 8'h01);
    end
    rd(ADDR_AUTO_ACK, 8'h3f);
    rd(5'h05, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    // Each source pulls the line low unless its own mask is set
    for (int i = 0; i < 3; i++) begin
      flagPulse(3'h1 << i, 3'h0);
      chk(radioIrqLineN, 8'h00);
      wr(ADDR_CONFIG, 8'h40 >> i);
      chk(radioIrqLineN, 8'h01);
      wr(ADDR_CONFIG, 8'h70 ^ (8'h40 >> i));
      chk(radioIrqLineN, 8'h00);
      flagPulse(3'h0, 3'h1 << i);
      chk(radioIrqLineN, 8'h01);
      wr(ADDR_CONFIG, 8'h00);
    end
    end_sim();
  end
endmodule : radio_config_register_bank_tb
`default_nettype wire
